// ### rtl/pms_pvd.sv
`timescale 1ns/1ps
`default_nettype none
// Programmable voltage detector edge logic.
module pms_pvd (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic above_in,
	input wire logic enable_in,
	input wire logic fall_en_in,
	input wire logic rise_en_in,
	output logic event_out,
	output logic output_out
);
	logic prev_above;
	logic armed;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			prev_above <= 1'b0;
			armed <= 1'b0;
			event_out <= 1'b0;
			output_out <= 1'b0;
		end
		else
		begin
			prev_above <= above_in;
			armed <= enable_in;
			output_out <= enable_in & ~above_in;
			event_out <= enable_in & armed &
				((fall_en_in & prev_above & ~above_in) | (rise_en_in & ~prev_above & above_in));
		end
	end
endmodule
`default_nettype wire

// ### rtl/pms_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for asynchronous pin and analog comparator levels.
module pms_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	if (WIDTH < 1)
	begin : g_width_check
		$error("pms_sync: WIDTH must be at least 1.");
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// ### rtl/pms_top.sv
`timescale 1ns/1ps
`default_nettype none
module pms_top import pms_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	// AXI4-Lite slave.
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Supply comparators and pins, all asynchronous.
	input wire logic por_above_in,
	input wire logic [PMS_BOR_LEVELS-1:0] bor_above_in,
	input wire logic pvd_above_in,
	input wire logic supervisor_enable_pin_in,
	input wire logic external_reset_pin_n_in,
	input wire logic independent_watchdog_reset_in,
	input wire logic wakeup_pin_in,
	input wire logic main_supply_present_in,
	input wire logic regulator_bypass_in,
	input wire pms_wake_s wake_in,
	// Same-clock peripheral events and option-byte loader.
	input wire logic periph_event_in,
	input wire logic optload_done_in,
	input wire logic [1:0] optload_bor_sel_in,
	output logic optload_req_out,
	output logic system_reset_n_out,
	output pms_clk_s clk_ctrl_out,
	output pms_power_s power_out,
	output logic pvd_irq_out,
	output logic pvd_output_out,
	output logic [5:0] state_out
);
	localparam int SYNC_W = 8 + PMS_BOR_LEVELS + PMS_EXT_LINES + PMS_RTC_EVENTS;

	if (ADDR_W < 4 || ADDR_W > 32)
	begin : g_addr_w_check
		$error("pms_top: ADDR_W must lie between 4 and 32.");
	end

	// ***************************************************************
	// Input synchronisation.
	// ***************************************************************
	logic [SYNC_W-1:0] sync_vec;
	logic por_ok;
	logic [PMS_BOR_LEVELS-1:0] bor_ok;
	logic pvd_above;
	logic sup_en;
	logic rst_pin_n;
	logic independent_watchdog_rst;
	logic wakeup_pin;
	logic main_present;
	logic bypass;
	pms_wake_s wake;

	pms_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.async_in({por_above_in, bor_above_in, pvd_above_in, supervisor_enable_pin_in,
			external_reset_pin_n_in, independent_watchdog_reset_in, wakeup_pin_in,
			main_supply_present_in, regulator_bypass_in, wake_in}),
		.sync_out(sync_vec)
	);

	assign {por_ok, bor_ok, pvd_above, sup_en, rst_pin_n, independent_watchdog_rst, wakeup_pin, main_present, bypass, wake} = sync_vec;

	// ***************************************************************
	// Register file state.
	// ***************************************************************
	pms_state_e state;
	pms_state_e next_state;
	logic pvd_en;
	logic pvd_fall;
	logic pvd_rise;
	pms_lp_e lp_mode;
	logic stop_lp;
	logic enter_req;
	logic pvd_flag;
	logic [1:0] bor_sel;
	logic bor_loaded;
	logic wakeup_pin_prev;
	logic pvd_evt;
	logic pvd_out;

	pms_pvd u_pvd (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.above_in(pvd_above),
		.enable_in(pvd_en),
		.fall_en_in(pvd_fall),
		.rise_en_in(pvd_rise),
		.event_out(pvd_evt),
		.output_out(pvd_out)
	);

	// ***************************************************************
	// Reset and supervision.
	// ***************************************************************
	logic supply_bad;
	logic reset_cause;
	logic core_off;
	logic ext_wake;
	logic rtc_wake;
	logic wakeup_pin_rise;

	always_comb
	begin
		supply_bad = 1'b0;
		if (sup_en)
		begin
			if (!por_ok)
				supply_bad = 1'b1;
			if (bor_loaded && bor_sel != PMS_BOR_DISABLED && !bor_ok[bor_sel])
				supply_bad = 1'b1;
		end
	end

	assign reset_cause = supply_bad | ~rst_pin_n | independent_watchdog_rst;
	assign core_off = (state == PMS_ST_RESET) || (state == PMS_ST_OPTLOAD) || (state == PMS_ST_STANDBY);
	assign ext_wake = main_present & ((|wake.ext_line) | pvd_evt | pvd_out);
	assign rtc_wake = main_present & (|wake.rtc_event);
	assign wakeup_pin_rise = wakeup_pin & ~wakeup_pin_prev;

	// ***************************************************************
	// Mode sequencer.
	// ***************************************************************
	always_comb
	begin
		next_state = state;
		unique case (state)
			PMS_ST_RESET:
				if (!reset_cause)
					next_state = PMS_ST_OPTLOAD;
			PMS_ST_OPTLOAD:
				if (optload_done_in)
					next_state = PMS_ST_RUN;
			PMS_ST_RUN:
				if (enter_req)
				begin
					unique case (lp_mode)
						PMS_LP_SLEEP: next_state = PMS_ST_SLEEP;
						PMS_LP_STOP: next_state = PMS_ST_STOP;
						PMS_LP_STANDBY: next_state = bypass ? PMS_ST_RUN : PMS_ST_STANDBY;
						PMS_LP_NONE: next_state = PMS_ST_RUN;
					endcase
				end
			PMS_ST_SLEEP:
				if (periph_event_in | ext_wake | rtc_wake)
					next_state = PMS_ST_RUN;
			PMS_ST_STOP:
				if (ext_wake | rtc_wake)
					next_state = PMS_ST_RUN;
			PMS_ST_STANDBY:
				if (wakeup_pin_rise | rtc_wake)
					next_state = PMS_ST_RESET;
			default:
				next_state = PMS_ST_RESET;
		endcase
		if (reset_cause)
			next_state = PMS_ST_RESET;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state <= PMS_ST_RESET;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			wakeup_pin_prev <= 1'b1;
		else
			wakeup_pin_prev <= wakeup_pin;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bor_sel <= PMS_BOR_DEFAULT;
			bor_loaded <= 1'b0;
		end
		else if (state == PMS_ST_OPTLOAD && optload_done_in)
		begin
			bor_sel <= optload_bor_sel_in;
			bor_loaded <= 1'b1;
		end
	end

	// ***************************************************************
	// AXI4-Lite slave.
	// ***************************************************************
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	function automatic logic [7:0] reg_ofs(input logic [ADDR_W-1:0] addr);
		logic [31:0] wide;
		wide = 32'(addr);
		return {wide[7:2], 2'h0};
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] addr);
		logic [31:0] wide;
		wide = 32'(addr);
		return wide[31:8] == 24'h0 && (reg_ofs(addr) == PMS_CTRL_OFS ||
			reg_ofs(addr) == PMS_STATUS_OFS || reg_ofs(addr) == PMS_FLAG_OFS);
	endfunction

	assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
	assign s_axi_wready_out = ~w_held & ~s_axi_bvalid_out;
	assign s_axi_arready_out = ~s_axi_rvalid_out;
	assign do_write = aw_held & w_held & ~s_axi_bvalid_out;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= PMS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= mapped(aw_addr) ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	// Control bits live in the core domain and are lost whenever it is off.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			pvd_en <= 1'b0;
			pvd_fall <= 1'b0;
			pvd_rise <= 1'b0;
			lp_mode <= PMS_LP_NONE;
			stop_lp <= 1'b0;
			enter_req <= 1'b0;
		end
		else if (core_off)
		begin
			pvd_en <= 1'b0;
			pvd_fall <= 1'b0;
			pvd_rise <= 1'b0;
			lp_mode <= PMS_LP_NONE;
			stop_lp <= 1'b0;
			enter_req <= 1'b0;
		end
		else
		begin
			enter_req <= 1'b0;
			if (do_write && reg_ofs(aw_addr) == PMS_CTRL_OFS && w_strb[0] && mapped(aw_addr))
			begin
				pvd_en <= w_data[PMS_CTRL_PVD_EN];
				pvd_fall <= w_data[PMS_CTRL_PVD_FALL];
				pvd_rise <= w_data[PMS_CTRL_PVD_RISE];
				lp_mode <= pms_lp_e'(w_data[PMS_CTRL_MODE_LSB +: 2]);
				stop_lp <= w_data[PMS_CTRL_STOP_LP];
				enter_req <= w_data[PMS_CTRL_ENTER];
			end
		end
	end

	// Detector flag: a new event wins over a same-cycle write-one clear.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			pvd_flag <= 1'b0;
		else if (pvd_evt)
			pvd_flag <= 1'b1;
		else if (core_off)
			pvd_flag <= 1'b0;
		else if (do_write && reg_ofs(aw_addr) == PMS_FLAG_OFS && w_strb[0] && w_data[PMS_FLAG_PVD])
			pvd_flag <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= PMS_RESP_OKAY;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= mapped(s_axi_araddr_in) ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
			s_axi_rdata_out <= 32'h0;
			if (mapped(s_axi_araddr_in))
			begin
				unique case (reg_ofs(s_axi_araddr_in))
					PMS_CTRL_OFS: s_axi_rdata_out <= {26'h0, stop_lp, lp_mode, pvd_rise, pvd_fall, pvd_en};
					PMS_STATUS_OFS: s_axi_rdata_out <= {20'h0, power_out.backup_from_battery, bypass,
						sup_en, bor_loaded, bor_sel, state};
					PMS_FLAG_OFS: s_axi_rdata_out <= {30'h0, pvd_out, pvd_flag};
					default: s_axi_rdata_out <= 32'h0;
				endcase
			end
		end
		else if (s_axi_rready_in)
			s_axi_rvalid_out <= 1'b0;
	end

	// ***************************************************************
	// Clock, power and reset outputs.
	// ***************************************************************
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			clk_ctrl_out <= '0;
			power_out <= '0;
			system_reset_n_out <= 1'b0;
			optload_req_out <= 1'b0;
		end
		else
		begin
			system_reset_n_out <= (next_state == PMS_ST_RUN) || (next_state == PMS_ST_SLEEP) ||
				(next_state == PMS_ST_STOP);
			optload_req_out <= next_state == PMS_ST_OPTLOAD;
			clk_ctrl_out.cpu_clk_en <= next_state == PMS_ST_RUN;
			clk_ctrl_out.core_clk_en <= (next_state == PMS_ST_RUN) || (next_state == PMS_ST_SLEEP);
			clk_ctrl_out.pll_en <= (next_state == PMS_ST_RUN) || (next_state == PMS_ST_SLEEP);
			clk_ctrl_out.internal_rc_oscillator_en <= (next_state != PMS_ST_STOP) &&
				(next_state != PMS_ST_STANDBY);
			clk_ctrl_out.external_crystal_oscillator_en <= (next_state == PMS_ST_RUN) ||
				(next_state == PMS_ST_SLEEP);
			power_out.regulator_on <= next_state != PMS_ST_STANDBY;
			power_out.core_power_on <= next_state != PMS_ST_STANDBY;
			power_out.regulator_low_power <= (next_state == PMS_ST_STOP) && stop_lp;
			// battery switch; only without main; needs supervisor
			power_out.backup_from_battery <= ~main_present & sup_en;
		end
	end

	assign pvd_irq_out = pvd_flag;
	assign pvd_output_out = pvd_out;
	assign state_out = state;

endmodule
`default_nettype wire

// ### shared/pms_pkg.sv
// Contract
// - Hold reset until supply passes power-on level, then start option-byte loading.
// - Option bytes pick one of three brownout levels or disable brownout reset.
// - Stay in reset while supply is below the active power-on or brownout level.
// - Internal supervisor works while its enable pin is high, off while low.
// - Enabled voltage detector interrupts on falling, rising, or both crossings.
// - Sleep stops only the processor clock; any peripheral interrupt or event wakes it.
// - Stop gates all core clocks and disables PLL and both oscillators, keeping state.
// - During Stop the regulator runs normal or low-power as configured.
// - Any external event line, detector output or clock event wakes from Stop.
// - Standby switches regulator off, powers core down, stops oscillators and PLL.
// - Standby exits on reset pin, watchdog reset, wakeup pin rise or clock event.
// - Standby is refused while the regulator is bypassed.
// - Backup domain is fed from main supply when present, else from the battery.
// - Battery operation starts only when the main supply is absent.
// - On battery, external interrupts and clock events do not end battery operation.
// - With supervisor off, battery operation is unavailable.
package pms_pkg;

	// ***************************************************************
	// Register map.
	// ***************************************************************
	localparam logic [7:0] PMS_CTRL_OFS = 8'h00;
	localparam logic [7:0] PMS_STATUS_OFS = 8'h04;
	localparam logic [7:0] PMS_FLAG_OFS = 8'h08;

	localparam int PMS_CTRL_PVD_EN = 0;
	localparam int PMS_CTRL_PVD_FALL = 1;
	localparam int PMS_CTRL_PVD_RISE = 2;
	localparam int PMS_CTRL_MODE_LSB = 3;
	localparam int PMS_CTRL_STOP_LP = 5;
	localparam int PMS_CTRL_ENTER = 6;
	localparam int PMS_FLAG_PVD = 0;
	localparam int PMS_FLAG_PVD_LEVEL = 1;

	localparam logic [1:0] PMS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PMS_RESP_SLVERR = 2'h2;

	// ***************************************************************
	// Brownout selection and low-power modes.
	// ***************************************************************
	localparam logic [1:0] PMS_BOR_DISABLED = 2'h3;
	localparam logic [1:0] PMS_BOR_DEFAULT = 2'h0;
	localparam int PMS_BOR_LEVELS = 3;
	localparam int PMS_EXT_LINES = 16;
	localparam int PMS_RTC_EVENTS = 4;

	typedef enum logic [1:0]
	{
		PMS_LP_NONE = 2'h0,
		PMS_LP_SLEEP = 2'h1,
		PMS_LP_STOP = 2'h2,
		PMS_LP_STANDBY = 2'h3
	} pms_lp_e;

	typedef enum logic [5:0]
	{
		PMS_ST_RESET = 6'h01,
		PMS_ST_OPTLOAD = 6'h02,
		PMS_ST_RUN = 6'h04,
		PMS_ST_SLEEP = 6'h08,
		PMS_ST_STOP = 6'h10,
		PMS_ST_STANDBY = 6'h20
	} pms_state_e;

	// ***************************************************************
	// Bundled carriers.
	// ***************************************************************
	typedef struct packed
	{
		logic [PMS_EXT_LINES-1:0] ext_line;
		logic [PMS_RTC_EVENTS-1:0] rtc_event;
	} pms_wake_s;

	typedef struct packed
	{
		logic cpu_clk_en;
		logic core_clk_en;
		logic pll_en;
		logic internal_rc_oscillator_en;
		logic external_crystal_oscillator_en;
	} pms_clk_s;

	typedef struct packed
	{
		logic regulator_on;
		logic regulator_low_power;
		logic core_power_on;
		logic backup_from_battery;
	} pms_power_s;

endpackage

// ### test/pms_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pms_assertions import pms_pkg::*; (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic por_above_in,
	input wire logic supervisor_enable_pin_in,
	input wire logic wakeup_pin_in,
	input wire logic main_supply_present_in,
	input wire logic regulator_bypass_in,
	input wire pms_wake_s wake_in,
	input wire logic periph_event_in,
	input wire logic optload_req_out,
	input wire logic system_reset_n_out,
	input wire pms_clk_s clk_ctrl_out,
	input wire pms_power_s power_out,
	input wire logic [5:0] state_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	low_supply_reset_a: assert property ((supervisor_enable_pin_in && !por_above_in) [*4] |=> !system_reset_n_out)
		else $error("Core reset released while supply is low.");
	load_after_por_a: assert property ($rose(optload_req_out) && supervisor_enable_pin_in |-> $past(por_above_in, 3))
		else $error("Option load began below the power-on level.");
	sleep_clocks_a: assert property (state_out == PMS_ST_SLEEP |-> !clk_ctrl_out.cpu_clk_en && clk_ctrl_out.core_clk_en)
		else $error("Sleep clock gating wrong.");
	sleep_wake_a: assert property (state_out == PMS_ST_SLEEP && periph_event_in |=> state_out == PMS_ST_RUN)
		else $error("Peripheral event did not end sleep.");
	stop_gating_a: assert property (state_out == PMS_ST_STOP |-> clk_ctrl_out == '0 && power_out.regulator_on)
		else $error("Stop clock or regulator state wrong.");
	stop_wake_a: assert property (state_out == PMS_ST_STOP && wake_in != '0 && main_supply_present_in
		|-> ##[1:4] state_out != PMS_ST_STOP)
		else $error("Event line did not end stop.");
	standby_power_a: assert property (state_out == PMS_ST_STANDBY
		|-> clk_ctrl_out == '0 && !power_out.regulator_on && !power_out.core_power_on)
		else $error("Standby left power or clocks on.");
	standby_pin_exit_a: assert property (state_out == PMS_ST_STANDBY && $rose(wakeup_pin_in) && main_supply_present_in
		|-> ##[1:6] state_out == PMS_ST_RESET)
		else $error("Wakeup pin rise did not end standby.");
	bypass_no_standby_a: assert property ((regulator_bypass_in && state_out != PMS_ST_STANDBY) [*4]
		|=> state_out != PMS_ST_STANDBY)
		else $error("Standby entered with regulator bypassed.");
	run_via_load_a: assert property ($rose(state_out == PMS_ST_RUN)
		|-> $past(state_out) != PMS_ST_RESET && $past(state_out) != PMS_ST_STANDBY)
		else $error("Run reached without option load.");
	battery_on_a: assert property ((!main_supply_present_in && supervisor_enable_pin_in) [*4]
		|=> power_out.backup_from_battery)
		else $error("Backup not switched to battery.");
	battery_off_a: assert property ((main_supply_present_in || !supervisor_enable_pin_in) [*4]
		|=> !power_out.backup_from_battery)
		else $error("Backup fed from battery wrongly.");
endmodule
bind pms_top pms_assertions pms_assertions_inst (.clk_in(clk_in), .resetn_in(resetn_in), .por_above_in(por_above_in),
	.supervisor_enable_pin_in(supervisor_enable_pin_in), .wakeup_pin_in(wakeup_pin_in),
	.main_supply_present_in(main_supply_present_in), .regulator_bypass_in(regulator_bypass_in), .wake_in(wake_in),
	.periph_event_in(periph_event_in), .optload_req_out(optload_req_out), .system_reset_n_out(system_reset_n_out),
	.clk_ctrl_out(clk_ctrl_out), .power_out(power_out), .state_out(state_out));
`default_nettype wire

// ### test/pms_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module pms_supply_model #(
	parameter int POR_MV = 1800,
	parameter int BOR_MV [3] = '{2100, 2400, 2700},
	parameter int PVD_MV = 2900
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [11:0] supply_mv_in,
	input wire logic supervisor_enable_pin_in,
	input wire logic reset_button_in,
	input wire logic slow_in,
	input wire logic [1:0] bor_sel_in,
	input wire logic optload_req_in,
	output logic por_above_out,
	output logic [2:0] bor_above_out,
	output logic pvd_above_out,
	output logic main_supply_present_out,
	output logic external_reset_pin_n_out,
	output logic optload_done_out,
	output logic [1:0] optload_bor_sel_out
);
	int mv;
	int cnt;
	assign mv = {20'h00000, supply_mv_in};
	assign por_above_out = mv >= POR_MV;
	assign pvd_above_out = mv >= PVD_MV;
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			bor_above_out[i] = mv >= BOR_MV[i];
	end
	assign main_supply_present_out = mv != 0;
	assign external_reset_pin_n_out = !reset_button_in && !(!supervisor_enable_pin_in && !por_above_out);
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in || !optload_req_in)
			cnt <= 0;
		else
			cnt <= cnt + 1;
	end
	assign optload_done_out = optload_req_in && cnt == (slow_in ? 12 : 1);
	assign optload_bor_sel_out = optload_done_out ? bor_sel_in : ~bor_sel_in;
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import pms_pkg::*;;
	localparam int BMV [3] = '{2100, 2400, 2700};
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, v;
	logic [1:0] br, rr, rs, sel, osel;
	logic awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
	logic [11:0] mv;
	logic sup, btn, slow, wdg, wkp, byp, pev, por, pvd, mains, rstn, odone, oreq, srst, irq, pout;
	logic [2:0] bor;
	logic [5:0] st;
	pms_wake_s wk;
	pms_clk_s ck;
	pms_power_s pw;
	int failures = 0;
	int checks = 0;
	int seed = 51850;
	always #4 clk_in = ~clk_in;
	pms_top pms_top_inst (.clk_in(clk_in), .resetn_in(resetn_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .por_above_in(por), .bor_above_in(bor),
		.pvd_above_in(pvd), .supervisor_enable_pin_in(sup), .external_reset_pin_n_in(rstn),
		.independent_watchdog_reset_in(wdg), .wakeup_pin_in(wkp), .main_supply_present_in(mains),
		.regulator_bypass_in(byp), .wake_in(wk), .periph_event_in(pev), .optload_done_in(odone),
		.optload_bor_sel_in(osel), .optload_req_out(oreq), .system_reset_n_out(srst), .clk_ctrl_out(ck),
		.power_out(pw), .pvd_irq_out(irq), .pvd_output_out(pout), .state_out(st));
	pms_supply_model #(.BOR_MV(BMV)) pms_supply_model_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.supply_mv_in(mv), .supervisor_enable_pin_in(sup), .reset_button_in(btn), .slow_in(slow), .bor_sel_in(sel),
		.optload_req_in(oreq), .por_above_out(por), .bor_above_out(bor), .pvd_above_out(pvd),
		.main_supply_present_out(mains), .external_reset_pin_n_out(rstn), .optload_done_out(odone),
		.optload_bor_sel_out(osel));
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (e !== g)
		begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 200)
		begin
			chk("wait bound", 0, n);
			give_verdict();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wait_st(input logic [5:0] s);
		int n;
		n = 0;
		while (st !== s && n < 200)
		begin
			@(posedge clk_in);
			n++;
		end
		tmo(n);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (awr && awv)
				awv <= 1'b0;
			if (wr && wv)
				wv <= 1'b0;
		end while (!bv && n < 200);
		rs = br;
		tmo(n);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (arr && arv)
				arv <= 1'b0;
		end while (!rv && n < 200);
		v = rd;
		rs = rr;
		tmo(n);
	endtask
	initial
	begin
		#600000;
		chk("run time", 0, 1);
		give_verdict();
	end
	initial
	begin
		{awv, wv, bry, arv, rry, btn, slow, wdg, wkp, byp, pev, awa, ara, wd, wk} = '0;
		sup = 1'b1;
		sel = 2'h1;
		mv = 12'h5DC;
		tick(6);
		resetn_in <= 1'b1;
		tick(12);
		chk("state below por", PMS_ST_RESET, st);
		chk("load request below por", 0, oreq);
		mv <= 12'hCE4;
		wait_st(PMS_ST_OPTLOAD);
		wait_st(PMS_ST_RUN);
		axi_rd(PMS_CTRL_OFS);
		chk("ctrl reset value", 0, v);
		axi_rd(8'h0C);
		chk("unmapped read", PMS_RESP_SLVERR, rs);
		axi_wr(8'h0C, 32'hFF);
		chk("unmapped write", PMS_RESP_SLVERR, rs);
		for (int k = 0; k < 4; k++)
		begin
			sel <= k[1:0];
			slow <= k[0];
			btn <= 1'b1;
			tick(3);
			btn <= 1'b0;
			wait_st(PMS_ST_OPTLOAD);
			wait_st(PMS_ST_RUN);
			axi_rd(PMS_STATUS_OFS);
			chk("loaded bor sel", {k[1:0], 1'b1}, {v[7:6], v[8]});
			mv <= (k < 3) ? 12'(BMV[k] - 50) : 12'h76C;
			tick(8);
			chk("brownout state", (k < 3) ? PMS_ST_RESET : PMS_ST_RUN, st);
			mv <= 12'hCE4;
			wait_st(PMS_ST_RUN);
		end
		for (int m = 1; m < 4; m++)
		begin
			axi_wr(PMS_CTRL_OFS, 32'(1 + 2 * m));
			mv <= 12'hB22;
			tick(6);
			chk("detector output", 1, pout);
			axi_rd(PMS_FLAG_OFS);
			chk("fall flag", m & 1, v[0]);
			axi_wr(PMS_FLAG_OFS, 32'h1);
			mv <= 12'hCE4;
			tick(6);
			chk("rise irq", m >> 1, irq);
			axi_wr(PMS_FLAG_OFS, 32'h1);
		end
		axi_wr(PMS_CTRL_OFS, 32'h48);
		wait_st(PMS_ST_SLEEP);
		chk("sleep clocks", 2'h1, {ck.cpu_clk_en, ck.core_clk_en});
		pev <= 1'b1;
		tick(1);
		pev <= 1'b0;
		wait_st(PMS_ST_RUN);
		for (int lp = 0; lp < 2; lp++)
		begin
			axi_wr(PMS_CTRL_OFS, 32'h50 | 32'(lp << 5));
			wait_st(PMS_ST_STOP);
			chk("stop clocks", 0, ck);
			chk("stop regulator mode", lp, pw.regulator_low_power);
			wk <= pms_wake_s'(20'h00001 << ($unsigned($random(seed)) % 20));
			wait_st(PMS_ST_RUN);
			wk <= '0;
			tick(4);
		end
		byp <= 1'b1;
		tick(4);
		axi_wr(PMS_CTRL_OFS, 32'h58);
		tick(8);
		chk("standby refused", PMS_ST_RUN, st);
		byp <= 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			tick(4);
			axi_wr(PMS_CTRL_OFS, 32'h58);
			wait_st(PMS_ST_STANDBY);
			chk("standby power", 0, {pw.regulator_on, pw.core_power_on, ck});
			{wkp, wdg, btn} <= 3'h4 >> c;
			wk.rtc_event <= (c == 3) ? 4'h1 << ($unsigned($random(seed)) % 4) : 4'h0;
			tick(3);
			{wkp, wdg, btn, wk} <= '0;
			wait_st(PMS_ST_OPTLOAD);
			chk("reload after standby", 1, oreq);
			wait_st(PMS_ST_RUN);
		end
		mv <= 12'h000;
		tick(6);
		chk("battery switch", 1, pw.backup_from_battery);
		wk <= pms_wake_s'(20'hFFFFF);
		tick(6);
		chk("battery kept", 1, pw.backup_from_battery);
		sup <= 1'b0;
		tick(6);
		chk("battery unavailable", 0, pw.backup_from_battery);
		chk("held by outer supervisor", 0, srst);
		{sup, wk} <= {1'b1, 20'h00000};
		mv <= 12'hCE4;
		tick(6);
		chk("mains feed backup", 0, pw.backup_from_battery);
		wait_st(PMS_ST_RUN);
		give_verdict();
	end
endmodule
`default_nettype wire
